/* src/tlc_pkg.sv */
// Purpose: shared constants for the top-level control register bank
// Assumes: 40 MHz mclk, 8-bit register port from the serial slave
// Notes:   timing counts are derived from the nominal times at 25 ns per cycle

package tlc_pkg;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] TOP_EVENT_FLAGS_ADDR = 8'h03;
  localparam logic [7:0] TOP_EVENT_MASK_ADDR  = 8'h04;
  localparam logic [7:0] TOP_SUP_CTRL_ADDR    = 8'h05;
  localparam logic [7:0] BUS_IF_CONFIG_ADDR   = 8'h40;
  localparam logic [7:0] SOFTWARE_RESET_KEY_KEY_ADDR    = 8'h50;
  localparam logic [7:0] SHIP_MODE_CTRL_ADDR  = 8'h51;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int THERMAL_SHUTDOWN_BIT   = 6;
  localparam int SYS_OVERVOLTAGE_BIT    = 5;
  localparam int SYS_UNDERVOLTAGE_BIT   = 4;
  localparam int POWER_UP_FAILURE_BIT   = 0;
  localparam int LOW_POWER_CYCLING_BIT  = 3;
  localparam int OVERVOLTAGE_OFF_BIT    = 2;
  localparam int OVERVOLTAGE_DEB_BIT    = 1;
  localparam int DIE_TEMP_OFF_BIT       = 0;
  localparam int EXT_SHIP_TIMER_BIT     = 0;
  localparam int PAIR_ADDRESS_BIT       = 4;
  localparam int HIGH_SPEED_EXT_BIT     = 0;

  // ************************************************************
  // reset values and masks
  // ************************************************************
  localparam logic [7:0] TOP_EVENT_MASK_RST = 8'hfe;
  localparam logic [7:0] TOP_SUP_CTRL_RST   = 8'h01;
  localparam logic [7:0] TOP_SUP_CTRL_WMASK = 8'h7f;
  localparam logic [7:0] BUS_IF_CONFIG_RST  = 8'h00;
  localparam logic [7:0] SOFTWARE_RESET_KEY_KEY_RST   = 8'h00;
  localparam logic [7:0] SHIP_MODE_CTRL_RST = 8'h00;
  localparam logic [7:0] EVENT_FLAG_BITS    = 8'h71;
  localparam logic [7:0] SOFTWARE_RESET_KEY_KEY_VALUE = 8'ha5;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int TMR_W          = 19;
  localparam int CLK_PERIOD_NS  = 25;
  localparam int LP_PERIOD_US   = 3000;
  localparam int OV_DEBOUNCE_US = 5000;
  localparam int SHIP_LONG_US   = 10000;
  localparam int SHIP_SHORT_US  = 100;
  localparam int LP_PERIOD_CYC   = LP_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int OV_DEBOUNCE_CYC = (OV_DEBOUNCE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SHIP_LONG_CYC   = SHIP_LONG_US * 1000 / CLK_PERIOD_NS;
  localparam logic [TMR_W-1:0] SHIP_SHORT_CYC = TMR_W'(SHIP_SHORT_US * 1000 / CLK_PERIOD_NS);

endpackage

/* src/tlc_timer_if.sv */
// Purpose: carries a run level, a limit and a done level to a hold timer
// Assumes: one clock domain
// Notes:   done stays high while run is held past the limit

`timescale 1ns/1ps
`default_nettype none

interface tlc_timer_if;
  logic                     run;
  logic [tlc_pkg::TMR_W-1:0] limit;
  logic                     done;
  modport owner (output run, output limit, input done);
  modport timer (input run, input limit, output done);
endinterface

`default_nettype wire

/* src/tlc_hold_timer.sv */
// Purpose: reports that run has been held for limit cycles
// Assumes: limit is at least one
// Notes:   dropping run restarts the count at once

`timescale 1ns/1ps
`default_nettype none

module tlc_hold_timer (
  input wire logic  mclk,   // system clock
  input wire logic  resetn, // async reset, active low
  tlc_timer_if.timer tif    // run, limit and done
);
  import tlc_pkg::*;

  logic [TMR_W-1:0] count_q;
  logic             done_q;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count_q <= '0;
    end else if (!tif.run) begin
      count_q <= '0;
    end else if (count_q != tif.limit) begin
      count_q <= count_q + 1'b1;
    end
  end

  // done rises on the edge that completes limit cycles of run
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      done_q <= 1'b0;
    end else begin
      done_q <= tif.run && (count_q >= tif.limit - 1'b1);
    end
  end

  assign tif.done = done_q;

endmodule

`default_nettype wire

/* src/tlc_top.sv */
// Purpose: top-level control and status registers of a one-cell charger
// Assumes: register port strobes come from the serial slave, one cycle each
// Notes:   long counts are parameters so that simulation can shorten them
//
// Behaviour
// - A power-up failure sets bit 0 of the event flag register on entry.
// - The thermal-shutdown mask is bit 6 of the mask register, reset to one, and one masks.
// - The over-voltage mask is bit 5 of the mask register, reset masked, and one masks.
// - The under-voltage mask is bit 4 of the mask register, reset masked, and one masks.
// - The power-up failure mask is bit 0 of the mask register and one masks its interrupt; the flag still sets.
// - With low-power cycling off the under-voltage comparator stays on and the others follow their disables.
// - With low-power cycling on the enabled comparators are switched on and off with a 3 ms period; a valid charger input keeps the thermal one on.
// - Control bit 2 turns the over-voltage comparator off when one and resets to zero.
// - Control bit 1 adds a 5 ms debounce to the rising over-voltage detection.
// - Control bit 0, reset to one, turns the die-temperature comparator off unless a valid charger input exists.
// - Bit 0 of the ship-mode register picks a 10 ms timer when zero and a 0.1 ms timer when one.
// - Bit 4 of the bus configuration register selects pair addressing in write bursts, reset zero.
// - The thermal, over-voltage and under-voltage flags set on entry and a read clears all flags.
// - Bit 0 of the bus configuration register enables the high-speed extension mode.

`timescale 1ns/1ps
`default_nettype none

module tlc_top #(
  parameter logic [tlc_pkg::TMR_W-1:0] LP_PERIOD_CYC   = tlc_pkg::TMR_W'(tlc_pkg::LP_PERIOD_CYC),
  parameter logic [tlc_pkg::TMR_W-1:0] OV_DEBOUNCE_CYC = tlc_pkg::TMR_W'(tlc_pkg::OV_DEBOUNCE_CYC),
  parameter logic [tlc_pkg::TMR_W-1:0] SHIP_LONG_CYC   = tlc_pkg::TMR_W'(tlc_pkg::SHIP_LONG_CYC)
) (
  input  wire logic       mclk,              // system clock, 40 MHz
  input  wire logic       resetn,            // async reset, active low
  input  wire logic       reg_wr_en,         // register write strobe
  input  wire logic       reg_rd_en,         // register read strobe
  input  wire logic [7:0] reg_addr,          // register offset
  input  wire logic [7:0] reg_wdata,         // write data
  output logic      [7:0] reg_rdata_q,       // read data, one cycle after strobe
  input  wire logic       thermal_raw,       // die over-temperature comparator
  input  wire logic       overvoltage_raw,   // system over-voltage comparator
  input  wire logic       undervoltage_raw,  // system under-voltage comparator
  input  wire logic       power_up_fail_raw, // power-up failure detector
  input  wire logic       charger_input_ok,  // valid charger input supply
  input  wire logic       ship_request,      // external ship-mode request level
  output logic            uvlo_comp_en_q,    // under-voltage comparator enable
  output logic            ovlo_comp_en_q,    // over-voltage comparator enable
  output logic            thermal_comparator_comp_en_q,   // thermal comparator enable
  output logic            event_irq_q,       // interrupt request, active high
  output logic            ship_expired_q,    // ship request held for timer duration
  output logic            pair_mode_q,       // pair addressing in write bursts
  output logic            hs_ext_q           // high-speed extension enabled
);
  import tlc_pkg::*;

  // ************************************************************
  // registers and register port
  // ************************************************************
  logic [7:0] flags_q;
  logic [7:0] mask_q;
  logic [7:0] ctrl_q;
  logic [7:0] cnfg_q;
  logic [7:0] key_q;
  logic [7:0] ship_q;
  logic [7:0] set_d;
  logic       wr_mask;
  logic       wr_ctrl;
  logic       wr_cnfg;
  logic       wr_key;
  logic       wr_ship;
  logic       key_hit;
  logic       flag_read;

  assign wr_mask   = reg_wr_en && (reg_addr == TOP_EVENT_MASK_ADDR);
  assign wr_ctrl   = reg_wr_en && (reg_addr == TOP_SUP_CTRL_ADDR);
  assign wr_cnfg   = reg_wr_en && (reg_addr == BUS_IF_CONFIG_ADDR);
  assign wr_key    = reg_wr_en && (reg_addr == SOFTWARE_RESET_KEY_KEY_ADDR);
  assign wr_ship   = reg_wr_en && (reg_addr == SHIP_MODE_CTRL_ADDR);
  assign key_hit   = wr_key && (reg_wdata == SOFTWARE_RESET_KEY_KEY_VALUE);
  assign flag_read = reg_rd_en && (reg_addr == TOP_EVENT_FLAGS_ADDR);

  // the key restores the supervisory registers; bus config survives so the link stays up
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mask_q <= TOP_EVENT_MASK_RST;
      ctrl_q <= TOP_SUP_CTRL_RST;
      ship_q <= SHIP_MODE_CTRL_RST;
      key_q  <= SOFTWARE_RESET_KEY_KEY_RST;
    end else if (key_hit) begin
      mask_q <= TOP_EVENT_MASK_RST;
      ctrl_q <= TOP_SUP_CTRL_RST;
      ship_q <= SHIP_MODE_CTRL_RST;
      key_q  <= SOFTWARE_RESET_KEY_KEY_RST;
    end else begin
      if (wr_mask) mask_q <= reg_wdata;
      if (wr_ctrl) ctrl_q <= reg_wdata & TOP_SUP_CTRL_WMASK;
      if (wr_ship) ship_q <= reg_wdata;
      if (wr_key)  key_q  <= reg_wdata;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnfg_q <= BUS_IF_CONFIG_RST;
    end else if (wr_cnfg) begin
      cnfg_q <= reg_wdata;
    end
  end

  // unmapped offsets read as zero
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd_en) begin
      case (reg_addr)
        TOP_EVENT_FLAGS_ADDR: reg_rdata_q <= flags_q;
        TOP_EVENT_MASK_ADDR:  reg_rdata_q <= mask_q;
        TOP_SUP_CTRL_ADDR:    reg_rdata_q <= ctrl_q;
        BUS_IF_CONFIG_ADDR:   reg_rdata_q <= cnfg_q;
        SOFTWARE_RESET_KEY_KEY_ADDR:    reg_rdata_q <= key_q;
        SHIP_MODE_CTRL_ADDR:  reg_rdata_q <= ship_q;
        default:              reg_rdata_q <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pair_mode_q <= 1'b0;
      hs_ext_q    <= 1'b0;
    end else begin
      pair_mode_q <= cnfg_q[PAIR_ADDRESS_BIT];
      hs_ext_q    <= cnfg_q[HIGH_SPEED_EXT_BIT];
    end
  end

  // ************************************************************
  // comparator power control
  // ************************************************************
  logic             lp_cycling;
  logic             lp_on;
  logic [TMR_W-1:0] lp_cnt_q;

  assign lp_cycling = ctrl_q[LOW_POWER_CYCLING_BIT];
  assign lp_on      = !lp_cycling || (lp_cnt_q < (LP_PERIOD_CYC >> 1));

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      lp_cnt_q <= '0;
    end else if (!lp_cycling || (lp_cnt_q == LP_PERIOD_CYC - 1'b1)) begin
      lp_cnt_q <= '0;
    end else begin
      lp_cnt_q <= lp_cnt_q + 1'b1;
    end
  end

  // a valid charger input pins the thermal comparator on, even through cycling
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      uvlo_comp_en_q  <= 1'b0;
      ovlo_comp_en_q  <= 1'b0;
      thermal_comparator_comp_en_q <= 1'b0;
    end else begin
      uvlo_comp_en_q  <= lp_on;
      ovlo_comp_en_q  <= !ctrl_q[OVERVOLTAGE_OFF_BIT] && lp_on;
      thermal_comparator_comp_en_q <= charger_input_ok || (!ctrl_q[DIE_TEMP_OFF_BIT] && lp_on);
    end
  end

  // ************************************************************
  // fault sensing and event flags
  // ************************************************************
  tlc_timer_if deb_if ();
  tlc_timer_if ship_if ();

  assign deb_if.run   = overvoltage_raw && ctrl_q[OVERVOLTAGE_DEB_BIT] && !ctrl_q[OVERVOLTAGE_OFF_BIT];
  assign deb_if.limit = OV_DEBOUNCE_CYC;

  tlc_hold_timer u_ov_debounce (
    .mclk   (mclk),
    .resetn (resetn),
    .tif    (deb_if)
  );

  logic ov_level;
  logic thermal_comparator_seen_q;
  logic ovlo_seen_q;
  logic uvlo_seen_q;
  logic pwrup_seen_q;

  assign ov_level = ctrl_q[OVERVOLTAGE_DEB_BIT] ? deb_if.done : overvoltage_raw;

  // a switched-off comparator holds its last reading, so cycling makes no false entries
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      thermal_comparator_seen_q <= 1'b0;
      ovlo_seen_q  <= 1'b0;
      uvlo_seen_q  <= 1'b0;
      pwrup_seen_q <= 1'b0;
    end else begin
      if (thermal_comparator_comp_en_q) thermal_comparator_seen_q <= thermal_raw;
      if (ovlo_comp_en_q)  ovlo_seen_q  <= ov_level;
      if (uvlo_comp_en_q)  uvlo_seen_q  <= undervoltage_raw;
      pwrup_seen_q <= power_up_fail_raw;
    end
  end

  always_comb begin
    set_d = 8'h00;
    set_d[THERMAL_SHUTDOWN_BIT] = thermal_comparator_comp_en_q && thermal_raw && !thermal_comparator_seen_q;
    set_d[SYS_OVERVOLTAGE_BIT]  = ovlo_comp_en_q && ov_level && !ovlo_seen_q;
    set_d[SYS_UNDERVOLTAGE_BIT] = uvlo_comp_en_q && undervoltage_raw && !uvlo_seen_q;
    set_d[POWER_UP_FAILURE_BIT] = power_up_fail_raw && !pwrup_seen_q;
  end

  // a new entry in the read cycle survives the clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      flags_q <= 8'h00;
    end else if (flag_read) begin
      flags_q <= set_d;
    end else begin
      flags_q <= flags_q | set_d;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      event_irq_q <= 1'b0;
    end else begin
      event_irq_q <= |(flags_q & ~mask_q & EVENT_FLAG_BITS);
    end
  end

  // ************************************************************
  // external ship-mode timer
  // ************************************************************
  assign ship_if.run   = ship_request;
  assign ship_if.limit = ship_q[EXT_SHIP_TIMER_BIT] ? SHIP_SHORT_CYC : SHIP_LONG_CYC;

  tlc_hold_timer u_ship_timer (
    .mclk   (mclk),
    .resetn (resetn),
    .tif    (ship_if)
  );

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ship_expired_q <= 1'b0;
    end else begin
      ship_expired_q <= ship_if.done;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_key_write;
    reg_wr_en && (reg_addr == SOFTWARE_RESET_KEY_KEY_ADDR) && (reg_wdata == SOFTWARE_RESET_KEY_KEY_VALUE);
  endsequence

  sequence s_plain_key_write;
    reg_wr_en && (reg_addr == SOFTWARE_RESET_KEY_KEY_ADDR) && (reg_wdata != SOFTWARE_RESET_KEY_KEY_VALUE);
  endsequence

  a_key_restores: assert property (s_key_write |=> (mask_q == TOP_EVENT_MASK_RST) &&
    (ctrl_q == TOP_SUP_CTRL_RST) && (key_q == SOFTWARE_RESET_KEY_KEY_RST))
    else $error("reset key did not restore registers");

  a_plain_key_stored: assert property (s_plain_key_write |=> (key_q == $past(reg_wdata)) &&
    $stable(mask_q) && $stable(ctrl_q))
    else $error("non-key write changed other registers");

  a_thermal_entry_flag: assert property (thermal_comparator_comp_en_q && thermal_raw && !thermal_comparator_seen_q
    |=> flags_q[THERMAL_SHUTDOWN_BIT])
    else $error("thermal entry not flagged");

  a_pwrup_entry_flag: assert property ($rose(power_up_fail_raw) |=> flags_q[POWER_UP_FAILURE_BIT])
    else $error("power-up failure not flagged");

  a_read_clears_flags: assert property (flag_read && (set_d == 8'h00) |=> flags_q == 8'h00)
    else $error("flag read did not clear");

  a_irq_follows_mask: assert property (##1 event_irq_q == |($past(flags_q) & ~$past(mask_q) & EVENT_FLAG_BITS))
    else $error("interrupt does not follow masked flags");

  // three cycles, since the enables only come up on the first edge after reset release
  a_uvlo_always_on: assert property (!lp_cycling [*3] |-> uvlo_comp_en_q)
    else $error("under-voltage comparator off without cycling");

  a_lp_period_wrap: assert property (lp_cycling && (lp_cnt_q == LP_PERIOD_CYC - 1'b1) |=> lp_cnt_q == '0)
    else $error("cycling period wrong");

  a_ovlo_disabled: assert property (ctrl_q[OVERVOLTAGE_OFF_BIT] |=> !ovlo_comp_en_q)
    else $error("over-voltage comparator on while disabled");

  a_thermal_comparator_charger_on: assert property (charger_input_ok |=> thermal_comparator_comp_en_q)
    else $error("thermal comparator off with charger input");

  a_deb_bypass: assert property (!ctrl_q[OVERVOLTAGE_DEB_BIT] && ovlo_comp_en_q && overvoltage_raw
    |=> ovlo_seen_q)
    else $error("over-voltage not seen without debounce");

endmodule

`default_nettype wire

/* bench/tlc_host_model.sv */
// Purpose: host side of the register strobe port, issuing single reads and writes
// Assumes: one strobe per transfer, read data valid the cycle after the strobe
// Notes:   released address and data show the inverse of the last value

`timescale 1ns/1ps
`default_nettype none

module tlc_host_model (
  input  wire logic       mclk,    // system clock
  output var  logic       wr_en,   // write strobe
  output var  logic       rd_en,   // read strobe
  output var  logic [7:0] addr,    // register offset
  output var  logic [7:0] wdata,   // write data
  input  wire logic [7:0] rdata    // read data from the bank
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr  = 8'h00;
    wdata = 8'h00;
  end

  // ************************************************************
  // transfers
  // ************************************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge mclk);
    wr_en <= 1'b0;
    // stale values would hide a bank that samples late
    addr  <= ~a;
    wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge mclk);
    rd_en <= 1'b0;
    addr  <= ~a;
    #1;
    d = rdata;
  endtask

  // the key restores the mask, control, ship-mode and key registers, not bus config
  task automatic soft_reset();
    wr(8'h50, 8'ha5);
  endtask
endmodule

`default_nettype wire

/* bench/tb_top_level_control_registers.sv */
// Purpose: self-checking bench for the top-level control register bank
// Assumes: shortened counts 40, 20 and 50 cycles
// Notes:   faults are driven as synchronous levels on the rising edge

`timescale 1ns/1ps
`default_nettype none

module tb_top_level_control_registers;
  import tlc_pkg::*;
  logic       mclk, resetn, wr_en, rd_en, thermal_comparator, ov, uv, pu, chg, ship;
  logic [7:0] addr, wdata, rdata;
  logic       uv_en, ov_en, th_en, irq, ship_exp, pair, hs, prev_uv;
  int         n_fail, checks, c_uv, c_ov, c_th, c_rise;

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  tlc_host_model host (.mclk(mclk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata));

  tlc_top #(.LP_PERIOD_CYC(19'd40), .OV_DEBOUNCE_CYC(19'd20), .SHIP_LONG_CYC(19'd50)) dut (
    .mclk(mclk), .resetn(resetn), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata_q(rdata), .thermal_raw(thermal_comparator), .overvoltage_raw(ov),
    .undervoltage_raw(uv), .power_up_fail_raw(pu), .charger_input_ok(chg), .ship_request(ship),
    .uvlo_comp_en_q(uv_en), .ovlo_comp_en_q(ov_en), .thermal_comparator_comp_en_q(th_en), .event_irq_q(irq),
    .ship_expired_q(ship_exp), .pair_mode_q(pair), .hs_ext_q(hs));

  // ************************************************************
  // checks and run control
  // ************************************************************
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: level %b, wanted %b", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    chk8(d, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic faults(input logic t, input logic o, input logic u, input logic p);
    @(posedge mclk);
    thermal_comparator <= t;
    ov    <= o;
    uv    <= u;
    pu    <= p;
  endtask

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // watchdog: the tests need about 4300 cycles
  initial begin
    repeat (30000) @(posedge mclk);
    n_fail++;
    $display("unexpected at %0t: run did not finish", $time);
    end_of_test();
  end

  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    {resetn, thermal_comparator, ov, uv, pu, chg, ship} = 7'h00;
    n_fail = 0;
    checks = 0;
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    rdchk(8'h04, 8'hfe);
    rdchk(8'h05, 8'h01);
    rdchk(8'h40, 8'h00);
    rdchk(8'h50, 8'h00);
    rdchk(8'h51, 8'h00);
    rdchk(8'h03, 8'h00);
    host.wr(8'h10, 8'hff);
    rdchk(8'h10, 8'h00);
    host.wr(8'h05, 8'hff);
    rdchk(8'h05, 8'h7f);
    $display("test reset_values done");

    host.wr(8'h05, 8'h00);
    faults(1'b0, 1'b0, 1'b0, 1'b1);
    cyc(4);
    chk1(irq, 1'b1);
    rdchk(8'h03, 8'h01);
    rdchk(8'h03, 8'h00);
    chk1(irq, 1'b0);
    host.wr(8'h04, 8'h8e);
    faults(1'b1, 1'b1, 1'b1, 1'b0);
    cyc(4);
    chk1(irq, 1'b1);
    rdchk(8'h03, 8'h70);
    faults(1'b0, 1'b0, 1'b0, 1'b0);
    host.wr(8'h04, 8'hff);
    faults(1'b1, 1'b1, 1'b1, 1'b1);
    cyc(4);
    chk1(irq, 1'b0);
    rdchk(8'h03, 8'h71);
    faults(1'b0, 1'b0, 1'b0, 1'b0);
    $display("test events_and_masks done");

    host.wr(8'h05, 8'h04);
    cyc(2);
    chk1(ov_en, 1'b0);
    chk1(uv_en, 1'b1);
    chk1(th_en, 1'b1);
    host.wr(8'h05, 8'h01);
    cyc(2);
    chk1(ov_en, 1'b1);
    chk1(th_en, 1'b0);
    @(posedge mclk);
    chg <= 1'b1;
    cyc(3);
    chk1(th_en, 1'b1);
    @(posedge mclk);
    chg <= 1'b0;
    host.wr(8'h05, 8'h08);
    cyc(2);
    {c_uv, c_ov, c_th} = '0;
    c_rise  = 0;
    prev_uv = uv_en;
    // one full period of samples: exactly one switch-on shows the period, not only the duty
    repeat (40) begin
      cyc(1);
      c_uv += int'(uv_en);
      c_ov += int'(ov_en);
      c_th += int'(th_en);
      c_rise += int'(uv_en && !prev_uv);
      prev_uv = uv_en;
    end
    chk8(8'(c_rise), 8'h01);
    chk8(8'(c_uv), 8'h14);
    chk8(8'(c_ov), 8'h14);
    chk8(8'(c_th), 8'h14);
    $display("test comparator_enables done");

    host.wr(8'h05, 8'h02);
    rdchk(8'h03, 8'h00);
    faults(1'b0, 1'b1, 1'b0, 1'b0);
    cyc(10);
    rdchk(8'h03, 8'h00);
    cyc(20);
    rdchk(8'h03, 8'h20);
    faults(1'b0, 1'b0, 1'b0, 1'b0);
    $display("test overvoltage_debounce done");

    @(posedge mclk);
    ship <= 1'b1;
    cyc(40);
    chk1(ship_exp, 1'b0);
    cyc(20);
    chk1(ship_exp, 1'b1);
    @(posedge mclk);
    ship <= 1'b0;
    host.wr(8'h51, 8'h01);
    @(posedge mclk);
    ship <= 1'b1;
    cyc(3980);
    chk1(ship_exp, 1'b0);
    cyc(40);
    chk1(ship_exp, 1'b1);
    @(posedge mclk);
    ship <= 1'b0;
    $display("test ship_timer done");

    host.wr(8'h40, 8'h11);
    host.wr(8'h05, 8'h0e);
    host.wr(8'h04, 8'h00);
    cyc(2);
    chk1(pair, 1'b1);
    chk1(hs, 1'b1);
    host.wr(8'h50, 8'h33);
    rdchk(8'h50, 8'h33);
    rdchk(8'h05, 8'h0e);
    host.soft_reset();
    rdchk(8'h04, 8'hfe);
    rdchk(8'h05, 8'h01);
    rdchk(8'h51, 8'h00);
    rdchk(8'h50, 8'h00);
    rdchk(8'h40, 8'h11);
    host.wr(8'h40, 8'h00);
    cyc(2);
    chk1(pair, 1'b0);
    chk1(hs, 1'b0);
    $display("test soft_reset done");
    end_of_test();
  end
endmodule

`default_nettype wire
